// ### bench/i2c_master_model.sv
// behavioural two-wire bus master that sends bytes to the slave receiver
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_low,
  output logic sda_low
);
  // high when the last byte saw sda pulled low in its acknowledge slot
  logic ack_low = 1'b0;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // scl stands still between frames; a slave holding it low stretches us
  task automatic pulse(output logic s);
    #40 scl_low = 1'b0;
    wait (scl_line === 1'b1);
    s = sda_line;
    #80 scl_low = 1'b1;
    #40;
  endtask
  task automatic start_cond();
    sda_low = 1'b1;
    #80 scl_low = 1'b1;
    #40;
  endtask
  task automatic send_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      pulse(s);
    end
    // sda released for the acknowledge slot
    sda_low = 1'b0;
    pulse(s);
    ack_low = ~s;
  endtask
  task automatic stop_cond();
    sda_low = 1'b1;
    #40 scl_low = 1'b0;
    wait (scl_line === 1'b1);
    #80 sda_low = 1'b0;
    #80;
  endtask
endmodule // i2c_master_model
`default_nettype wire

// ### bench/i2c_receive_handshake_ctrl_bench.sv
// register-level bench for the receive handshake controller
`timescale 1ns/100ps
`default_nettype none
module i2c_receive_handshake_ctrl_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] s_axi_awaddr = 5'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [4:0] s_axi_araddr = 5'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic scl_o, scl_oe, sda_o, sda_oe, irq, m_scl_low, m_sda_low;
  wire logic scl_line = !((scl_oe & ~scl_o) | m_scl_low);
  wire logic sda_line = !((sda_oe & ~sda_o) | m_sda_low);
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [1:0] rsp;

  always #5 aclk = ~aclk;

  i2c_receive_handshake_ctrl i_i2c_receive_handshake_ctrl (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .scl_i(scl_line), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .irq(irq)
  );
  i2c_master_model i_i2c_master_model (
    .scl_line(scl_line), .sda_line(sda_line), .scl_low(m_scl_low),
    .sda_low(m_sda_low)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // a hang anywhere ends up in the same closing report
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // outputs are registered, so values read right after the edge are pre-edge
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [4:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    axi_write(a, d, rsp);
    check("write response", {30'h0, i2c_rx_hs_pkg::RESP_OKAY}, {30'h0, rsp});
  endtask

  task automatic rd_chk(input string name, input logic [4:0] a,
                        input logic [31:0] exp);
    axi_read(a, rd, rsp);
    check(name, exp, rd);
  endtask

  task automatic one_byte(input logic [7:0] b);
    i_i2c_master_model.send_byte(b);
    wait_clk(12);
  endtask

  initial begin
    wait_clk(6);
    aresetn <= 1'b1;
    wait_clk(2);
    rd_chk("ext reset", i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'h0);
    wr(i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'he0);
    rd_chk("ext rw", i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'hc0);
    wr(i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'h00);
    rd_chk("ext clear", i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'h0);
    axi_read(5'h14, rd, rsp);
    check("unmapped rresp", 32'h2, {30'h0, rsp});
    axi_write(5'h18, 32'hff, rsp);
    check("unmapped bresp", 32'h2, {30'h0, rsp});
    wr(i2c_rx_hs_pkg::OFF_CTRL, 32'h1);
    wr(i2c_rx_hs_pkg::OFF_IRQ_MASK, 32'h1);
    // plain receive, stop interrupt unmasked
    i_i2c_master_model.start_cond();
    one_byte(8'ha5);
    rd_chk("flag set", i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'h20);
    check("scl free", 32'h0, {31'h0, scl_oe});
    check("ack seen", 32'h1, {31'h0, i_i2c_master_model.ack_low});
    check("ack released", 32'h0, {31'h0, sda_oe});
    check("pins pull low", 32'h0, {30'h0, scl_o, sda_o});
    i_i2c_master_model.stop_cond();
    wait_clk(12);
    rd_chk("irq status", i2c_rx_hs_pkg::OFF_IRQ_STAT, 32'h3);
    check("irq raised", 32'h1, {31'h0, irq});
    rd_chk("data", i2c_rx_hs_pkg::OFF_DATA, 32'ha5);
    rd_chk("flag read clr", i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'h0);
    wr(i2c_rx_hs_pkg::OFF_IRQ_STAT, 32'h3);
    wait_clk(2);
    check("irq cleared", 32'h0, {31'h0, irq});
    // second byte lands while the first still waits
    i_i2c_master_model.start_cond();
    one_byte(8'h5a);
    check("scl free 2", 32'h0, {31'h0, scl_oe});
    one_byte(8'hc3);
    rd_chk("first kept", i2c_rx_hs_pkg::OFF_DATA, 32'h5a);
    rd_chk("flag again", i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'h20);
    rd_chk("pending moved", i2c_rx_hs_pkg::OFF_DATA, 32'hc3);
    rd_chk("flag empty", i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'h0);
    // handshake: clock held until the byte is read
    wr(i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'h40);
    one_byte(8'h3c);
    check("scl held", 32'h1, {31'h0, scl_oe});
    rd_chk("hs data", i2c_rx_hs_pkg::OFF_DATA, 32'h3c);
    wait_clk(2);
    check("scl released", 32'h0, {31'h0, scl_oe});
    wr(i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'hc0);
    wr(i2c_rx_hs_pkg::OFF_IRQ_STAT, 32'h3);
    i_i2c_master_model.stop_cond();
    wait_clk(12);
    rd_chk("masked stop", i2c_rx_hs_pkg::OFF_IRQ_STAT, 32'h0);
    check("irq quiet", 32'h0, {31'h0, irq});
    // transmit mode never fills the receive buffer
    wr(i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'h00);
    wr(i2c_rx_hs_pkg::OFF_CTRL, 32'h3);
    i_i2c_master_model.start_cond();
    one_byte(8'h77);
    check("tx nack", 32'h0, {31'h0, i_i2c_master_model.ack_low});
    i_i2c_master_model.stop_cond();
    rd_chk("tx no flag", i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'h0);
    rd_chk("tx stale", i2c_rx_hs_pkg::OFF_DATA, 32'h3c);
    // disabling the interface drops a waiting byte
    wr(i2c_rx_hs_pkg::OFF_CTRL, 32'h1);
    i_i2c_master_model.start_cond();
    one_byte(8'h11);
    rd_chk("flag before off", i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'h20);
    wr(i2c_rx_hs_pkg::OFF_CTRL, 32'h0);
    rd_chk("flag off", i2c_rx_hs_pkg::OFF_EXT_CTRL, 32'h0);
    i_i2c_master_model.stop_cond();
    finish_test();
  end
endmodule // i2c_receive_handshake_ctrl_bench
`default_nettype wire

// ### hw/i2c_pin_sync.sv
// two-flop synchronisers and edge detection for scl and sda
`timescale 1ns/100ps
`default_nettype none
module i2c_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_lvl,
  output logic scl_rise,
  output logic scl_fall,
  output logic sda_rise,
  output logic sda_fall
);
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] prev_r;

  // bus idles high, so reset to one avoids a false edge at release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 2'h3;
      sync_r <= 2'h3;
      prev_r <= 2'h3;
    end else begin
      meta_r <= {sda_i, scl_i};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign scl_lvl = sync_r[0];
  assign scl_rise = sync_r[0] & ~prev_r[0];
  assign scl_fall = ~sync_r[0] & prev_r[0];
  assign sda_rise = sync_r[1] & ~prev_r[1];
  assign sda_fall = ~sync_r[1] & prev_r[1];
endmodule // i2c_pin_sync
`default_nettype wire

// ### hw/i2c_receive_handshake_ctrl.sv
// receive handshake and stop interrupt control with axi4-lite registers
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module i2c_receive_handshake_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic irq
);
  logic scl_lvl, scl_rise, scl_fall, sda_rise, sda_fall;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_full_r, w_full_r;
  logic [4:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic stop_irq_mask_r, handshake_select_r, rx_ready_flag_r;
  localparam int IRQ_W = i2c_rx_hs_pkg::IRQ_W;
  logic iface_enable_r, transmit_select_r;
  logic [IRQ_W-1:0] irq_stat_r, irq_mask_r;
  logic [7:0] shift_register_r, rx_buffer_r;
  logic [3:0] bit_cnt_r;
  logic active_r, pend_r, move_r, hold_req_r, scl_hold_r, ack_drive_r;
  logic pin_low_r, irq_r;
  logic wr_fire, rd_fire, data_rd, rx_mode;
  logic start_det, stop_det, byte_done;
  logic sda_lvl_r;

  i2c_pin_sync i_i2c_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_lvl(scl_lvl),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .sda_rise(sda_rise),
    .sda_fall(sda_fall)
  );

  assign wr_fire = aw_full_r & w_full_r & ~bvalid_r;
  assign rd_fire = s_axi_arvalid & arready_r;
  assign data_rd = rd_fire & (s_axi_araddr == i2c_rx_hs_pkg::OFF_DATA);
  assign rx_mode = iface_enable_r & ~transmit_select_r;
  assign start_det = sda_fall & scl_lvl;
  assign stop_det = sda_rise & scl_lvl;
  assign byte_done = scl_rise & active_r & rx_mode &
                     (bit_cnt_r == i2c_rx_hs_pkg::CNT_BYTE);

  // write address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      aw_full_r <= 1'b0;
      awaddr_r <= 5'h00;
    end else if (s_axi_awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_full_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (bvalid_r && s_axi_bready) begin
      aw_full_r <= 1'b0;
    end else if (!aw_full_r) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b0;
      w_full_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_full_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (bvalid_r && s_axi_bready) begin
      w_full_r <= 1'b0;
    end else if (!w_full_r) begin
      wready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= i2c_rx_hs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      unique case (awaddr_r)
        i2c_rx_hs_pkg::OFF_EXT_CTRL, i2c_rx_hs_pkg::OFF_DATA,
        i2c_rx_hs_pkg::OFF_CTRL, i2c_rx_hs_pkg::OFF_IRQ_STAT,
        i2c_rx_hs_pkg::OFF_IRQ_MASK: bresp_r <= i2c_rx_hs_pkg::RESP_OKAY;
        default: bresp_r <= i2c_rx_hs_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // reads answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= i2c_rx_hs_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= i2c_rx_hs_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      unique case (s_axi_araddr)
        i2c_rx_hs_pkg::OFF_EXT_CTRL: begin
          rdata_r[i2c_rx_hs_pkg::STOP_IRQ_MASK_BIT] <= stop_irq_mask_r;
          rdata_r[i2c_rx_hs_pkg::HANDSHAKE_SEL_BIT] <= handshake_select_r;
          rdata_r[i2c_rx_hs_pkg::RX_READY_BIT] <= rx_ready_flag_r;
        end
        i2c_rx_hs_pkg::OFF_DATA: rdata_r[7:0] <= rx_buffer_r;
        i2c_rx_hs_pkg::OFF_CTRL: begin
          rdata_r[i2c_rx_hs_pkg::IFACE_EN_BIT] <= iface_enable_r;
          rdata_r[i2c_rx_hs_pkg::TX_SEL_BIT] <= transmit_select_r;
        end
        i2c_rx_hs_pkg::OFF_IRQ_STAT: rdata_r[IRQ_W-1:0] <= irq_stat_r;
        i2c_rx_hs_pkg::OFF_IRQ_MASK: rdata_r[IRQ_W-1:0] <= irq_mask_r;
        default: rresp_r <= i2c_rx_hs_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  // software bits; the ready flag has no write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_irq_mask_r <= 1'b0;
      handshake_select_r <= 1'b0;
      iface_enable_r <= 1'b0;
      transmit_select_r <= 1'b0;
      irq_mask_r <= i2c_rx_hs_pkg::IRQ_MASK_RST;
    end else if (wr_fire && wstrb_r[0]) begin
      if (awaddr_r == i2c_rx_hs_pkg::OFF_EXT_CTRL) begin
        stop_irq_mask_r <= wdata_r[i2c_rx_hs_pkg::STOP_IRQ_MASK_BIT];
        handshake_select_r <= wdata_r[i2c_rx_hs_pkg::HANDSHAKE_SEL_BIT];
      end
      if (awaddr_r == i2c_rx_hs_pkg::OFF_CTRL) begin
        iface_enable_r <= wdata_r[i2c_rx_hs_pkg::IFACE_EN_BIT];
        transmit_select_r <= wdata_r[i2c_rx_hs_pkg::TX_SEL_BIT];
      end
      if (awaddr_r == i2c_rx_hs_pkg::OFF_IRQ_MASK)
        irq_mask_r <= wdata_r[IRQ_W-1:0];
    end
  end

  // bus framing; addressing is not decoded, any frame is taken as ours
  always_ff @(posedge aclk) begin
    if (!aresetn || !iface_enable_r) begin
      active_r <= 1'b0;
      bit_cnt_r <= i2c_rx_hs_pkg::CNT_ZERO;
      shift_register_r <= i2c_rx_hs_pkg::BYTE_RST;
    end else if (start_det) begin
      active_r <= 1'b1;
      bit_cnt_r <= i2c_rx_hs_pkg::CNT_ZERO;
    end else if (stop_det) begin
      active_r <= 1'b0;
    end else if (scl_rise && active_r) begin
      if (bit_cnt_r < i2c_rx_hs_pkg::CNT_BYTE) begin
        shift_register_r <= {shift_register_r[6:0], sda_lvl_r};
      end
      if (bit_cnt_r <= i2c_rx_hs_pkg::CNT_BYTE)
        bit_cnt_r <= bit_cnt_r + 4'h1;
    end else if (scl_fall && bit_cnt_r == i2c_rx_hs_pkg::CNT_ACK) begin
      bit_cnt_r <= i2c_rx_hs_pkg::CNT_ZERO;
    end
  end

  // sda level kept from its edges, so it is settled when scl rises
  always_ff @(posedge aclk) begin
    if (!aresetn)
      sda_lvl_r <= 1'b1;
    else
      sda_lvl_r <= sda_fall ? 1'b0 : (sda_rise ? 1'b1 : sda_lvl_r);
  end

  // acknowledge is driven low over the ninth clock in receive mode
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_mode || !active_r)
      ack_drive_r <= 1'b0;
    else if (scl_fall && bit_cnt_r == i2c_rx_hs_pkg::CNT_BYTE)
      ack_drive_r <= 1'b1;
    else if (scl_fall && bit_cnt_r == i2c_rx_hs_pkg::CNT_ACK)
      ack_drive_r <= 1'b0;
  end

  // ready flag, receive buffer and the deferred transfer
  always_ff @(posedge aclk) begin
    if (!aresetn || !iface_enable_r) begin
      rx_ready_flag_r <= 1'b0;
      rx_buffer_r <= i2c_rx_hs_pkg::BYTE_RST;
      pend_r <= 1'b0;
      move_r <= 1'b0;
    end else begin
      move_r <= 1'b0;
      if (move_r && !transmit_select_r) begin
        rx_buffer_r <= shift_register_r;
        rx_ready_flag_r <= 1'b1;
        pend_r <= 1'b0;
      end else if (data_rd) begin
        rx_ready_flag_r <= 1'b0;
        // a byte finishing under the read takes the deferred path
        if ((pend_r || byte_done) && rx_mode)
          move_r <= 1'b1;
      end else if (byte_done && !rx_ready_flag_r) begin
        rx_buffer_r <= shift_register_r;
        rx_ready_flag_r <= 1'b1;
      end else if (byte_done) begin
        pend_r <= 1'b1;
      end
    end
  end

  // scl is held after the ninth clock while a byte must wait for software;
  // a waiting byte also stalls the bus, or the next one would overwrite it
  always_ff @(posedge aclk) begin
    if (!aresetn || !iface_enable_r) begin
      hold_req_r <= 1'b0;
      scl_hold_r <= 1'b0;
    end else if (data_rd) begin
      hold_req_r <= byte_done & handshake_select_r;
      scl_hold_r <= 1'b0;
    end else if (byte_done) begin
      hold_req_r <= handshake_select_r | rx_ready_flag_r;
    end else if (scl_fall && bit_cnt_r == i2c_rx_hs_pkg::CNT_ACK) begin
      scl_hold_r <= hold_req_r;
      hold_req_r <= 1'b0;
    end
  end

  // sticky events; a new event beats a same-cycle write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= 2'h0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if (wr_fire && wstrb_r[0] && wdata_r[i] &&
            awaddr_r == i2c_rx_hs_pkg::OFF_IRQ_STAT)
          irq_stat_r[i] <= 1'b0;
      end
      if (stop_det && active_r && iface_enable_r && !stop_irq_mask_r)
        irq_stat_r[i2c_rx_hs_pkg::IRQ_STOP_BIT] <= 1'b1;
      if ((byte_done && !rx_ready_flag_r) || move_r)
        irq_stat_r[i2c_rx_hs_pkg::IRQ_RX_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= 1'b0;
      pin_low_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_mask_r);
      pin_low_r <= 1'b0;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign scl_o = pin_low_r;
  assign scl_oe = scl_hold_r;
  assign sda_o = pin_low_r;
  assign sda_oe = ack_drive_r;
  assign irq = irq_r;

  a_stop_irq_set: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_det && active_r && iface_enable_r && !stop_irq_mask_r |=>
    irq_stat_r[i2c_rx_hs_pkg::IRQ_STOP_BIT])
    else $error("unmasked stop did not set the interrupt flag");
  a_stop_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq_stat_r[i2c_rx_hs_pkg::IRQ_STOP_BIT]) |->
    !$past(stop_irq_mask_r))
    else $error("masked stop set the interrupt flag");
  a_no_hold_cont: assert property (@(posedge aclk) disable iff (!aresetn)
    byte_done && !handshake_select_r && !rx_ready_flag_r && !data_rd
    |=> !hold_req_r)
    else $error("scl hold requested with handshake off");
  a_hold_scl_low: assert property (@(posedge aclk) disable iff (!aresetn)
    byte_done && handshake_select_r && !data_rd ##1 !data_rd[*2]
    |-> hold_req_r || scl_hold_r)
    else $error("handshake byte left scl free");
  a_read_release: assert property (@(posedge aclk) disable iff (!aresetn)
    data_rd |=> !scl_oe)
    else $error("data read did not release scl");
  a_rx_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    byte_done && !rx_ready_flag_r && !data_rd && !move_r |=>
    rx_ready_flag_r && rx_buffer_r == $past(shift_register_r))
    else $error("completed byte not copied to the buffer");
  a_defer_move: assert property (@(posedge aclk) disable iff (!aresetn)
    data_rd && pend_r && rx_mode && !move_r |=> !rx_ready_flag_r
    ##1 (rx_ready_flag_r || !rx_mode))
    else $error("deferred byte did not move after the read");
  a_disable_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    !iface_enable_r |=> !rx_ready_flag_r)
    else $error("ready flag survived a disabled interface");
  a_tx_no_fill: assert property (@(posedge aclk) disable iff (!aresetn)
    transmit_select_r |=> rx_buffer_r == $past(rx_buffer_r) ||
    !$past(iface_enable_r))
    else $error("receive buffer changed in transmit mode");
  a_ctl_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && wstrb_r[0] && awaddr_r == i2c_rx_hs_pkg::OFF_EXT_CTRL |=>
    stop_irq_mask_r == $past(wdata_r[i2c_rx_hs_pkg::STOP_IRQ_MASK_BIT]) &&
    handshake_select_r ==
    $past(wdata_r[i2c_rx_hs_pkg::HANDSHAKE_SEL_BIT]))
    else $error("control bits did not take the written value");
endmodule // i2c_receive_handshake_ctrl
`default_nettype wire

// ### hw/i2c_rx_hs_pkg.sv
// constants for the receive handshake controller
package i2c_rx_hs_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_EXT_CTRL = 5'h00;
  localparam logic [4:0] OFF_DATA = 5'h04;
  localparam logic [4:0] OFF_CTRL = 5'h08;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h0c;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;
  // extended control fields
  localparam int STOP_IRQ_MASK_BIT = 7;
  localparam int HANDSHAKE_SEL_BIT = 6;
  localparam int RX_READY_BIT = 5;
  // plain control fields
  localparam int IFACE_EN_BIT = 0;
  localparam int TX_SEL_BIT = 1;
  // interrupt status and mask fields
  localparam int IRQ_STOP_BIT = 0;
  localparam int IRQ_RX_BIT = 1;
  localparam int IRQ_W = 2;
  // reset values
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // bit counter values
  localparam logic [3:0] CNT_BYTE = 4'h8;
  localparam logic [3:0] CNT_ACK = 4'h9;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
